/* File: bench/atm_asserts.sv */
/*
  atm_asserts: port checker for atm_trigger_mode, bound at the foot.
  assumes a zero wait state bus and a three edge trigger path.
*/
`timescale 1ns/1ps
`default_nettype none
module atm_asserts (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_timer_one,
  input wire logic i_comparator_one_output,
  input wire logic i_charge_time_unit,
  input wire logic [3:0] o_convert_request,
  input wire logic [7:0] o_input_differential,
  input wire logic [7:0] o_input_signed,
  input wire logic [4:0] o_scan_trigger_source
);
  logic ap_r;
  logic [7:0] a_r, ed, es;
  logic [31:0] wd_r;
  logic [4:0] sel_r, sel1_r;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // follows bus writes so the input 0 selection and the last word are known
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ap_r <= 1'h0;
      a_r <= 8'h00;
      wd_r <= 32'h0;
      sel_r <= 5'h00;
      sel1_r <= 5'h00;
    end else begin
      ap_r <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
      a_r <= i_haddr[7:0];
      if (ap_r) wd_r <= i_hwdata;
      if (ap_r && a_r == 8'h00) begin
        sel_r <= i_hwdata[4:0];
        sel1_r <= i_hwdata[12:8];
      end
    end
  end
  // expected mode outputs from the last written word
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      ed[k] = wd_r[2*k+7];
      es[k] = wd_r[2*k+6];
    end
  end
  sequence s_wr(logic [7:0] a);
    ap_r && a_r == a;
  endsequence
  AST_READY: assert property (i_htrans[1] |-> o_hreadyout ##1 o_hreadyout)
    else $error("bus stalled");
  AST_RESP: assert property (i_htrans[1] |-> ##1 !o_hresp) else $error("bus error response");
  AST_NONE: assert property (sel_r == 5'h00 && $past(sel_r, 4) == 5'h00 |->
    !o_convert_request[0]) else $error("request with no trigger selected");
  AST_NONE_ONE: assert property (sel1_r == 5'h00 && $past(sel1_r, 4) == 5'h00 |->
    !o_convert_request[1]) else $error("request on input 1 with no trigger selected");
  AST_TMR: assert property ($rose(i_timer_one) && sel_r == 5'h05 |->
    ##[2:5] o_convert_request[0]) else $error("timer match missed");
  AST_CMP: assert property ($rose(i_comparator_one_output) && sel_r == 5'h0b |->
    ##[2:5] o_convert_request[0]) else $error("comparator edge missed");
  AST_CTU: assert property ($rose(i_charge_time_unit) &&
    (sel_r == 5'h0d || sel_r == 5'h1d) |-> ##[2:5] o_convert_request[0])
    else $error("charge time event missed");
  AST_ONCE: assert property ($rose(o_convert_request[0]) && sel_r != 5'h02 |=>
    !o_convert_request[0]) else $error("request longer than one cycle");
  AST_SCAN: assert property (s_wr(8'h0c) |-> ##[1:2] o_scan_trigger_source == wd_r[20:16])
    else $error("scan source not updated");
  AST_DIFF: assert property (s_wr(8'h04) |-> ##[1:2] o_input_differential == ed)
    else $error("differential bits wrong");
  AST_SIGN: assert property (s_wr(8'h04) |-> ##[1:2] o_input_signed == es)
    else $error("signed bits wrong");
endmodule
bind atm_trigger_mode atm_asserts u_chk (.i_clock, .i_arst_n, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .i_timer_one,
  .i_comparator_one_output, .i_charge_time_unit, .o_convert_request,
  .o_input_differential, .o_input_signed, .o_scan_trigger_source);
`default_nettype wire

/* File: bench/atm_periph.sv */
/*
  atm_periph: model of the peripheral trigger sources.
  assumes the bench names one source and holds fire for two cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module atm_periph (
  input wire logic i_clock,
  input wire logic i_fire,
  input wire logic [3:0] i_idx,
  output logic [10:0] o_src = 11'h000
);
  // the named source is high while fired, all others stay low
  always @(posedge i_clock) begin
    o_src <= i_fire ? 11'h001 << i_idx : 11'h000;
  end
endmodule
`default_nettype wire

/* File: bench/atm_trigger_mode_bench.sv */
/*
  atm_trigger_mode_bench: self checking bench for atm_trigger_mode.
  assumes atm_periph drives the trigger sources; bench is the bus master.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, s); end end
module atm_trigger_mode_bench import atm_pkg::*; ;
  logic clk = 1'h0, rst_n = 1'h0, hwrite = 1'h0, fire = 1'h0, rd_ph = 1'h0, lvl = 1'h0;
  logic hrdy, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v, ev;
  logic [1:0] htrans = 2'h0;
  logic [3:0] idx = 4'h0, req, ec;
  logic [10:0] src;
  logic [7:0] dif, sgn;
  logic [4:0] scs, c;
  logic [31:0] rq[$];
  logic [3:0] cq[$];
  int mismatches = 0, n_compared = 0, seed = 36326;
  atm_trigger_mode DUT (.i_clock(clk), .i_arst_n(rst_n), .i_hsel(1'h1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_scan_trigger(src[0]),
    .i_external_interrupt_zero(src[1]), .i_timer_one(src[2]), .i_timer_three(src[3]),
    .i_timer_five(src[4]), .i_output_compare_one(src[5]), .i_output_compare_three(src[6]),
    .i_output_compare_five(src[7]), .i_comparator_one_output(src[8]),
    .i_comparator_two_output(src[9]), .i_charge_time_unit(src[10]),
    .o_convert_request(req), .o_input_differential(dif), .o_input_signed(sgn),
    .o_scan_trigger_source(scs));
  atm_periph u_periph (.i_clock(clk), .i_fire(fire), .i_idx(idx), .o_src(src));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // one single transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= ~w;
    do @(posedge clk); while (hrdy !== 1'h1);
    rd_ph <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    xfer(1'h0, a, 32'h0);
  endtask
  task automatic pulse(input logic [3:0] i);
    @(posedge clk);
    fire <= 1'h1;
    idx <= i;
    repeat (2) @(posedge clk);
    fire <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
  task wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // takes the oldest note whenever read data appears, or a request appears while lvl is low
  always @(posedge clk) begin
    if (rd_ph && hrdy) begin
      ev = rq.size() ? rq.pop_front() : 32'hx;
      `CHK("read data", ev, hrdata)
    end
    if (req !== 4'h0 && !lvl) begin
      ec = cq.size() ? cq.pop_front() : 4'hx;
      `CHK("request", ec, req)
    end
  end
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    rd(ATM_OFS_TRIG_SEL, 32'h0);
    rd(ATM_OFS_MODE_TWO, 32'h0);
    rd(8'h14, 32'h0);
    xfer(1'h1, ATM_OFS_TRIG_SEL, 32'hedededed);
    rd(ATM_OFS_TRIG_SEL, 32'h0d0d0d0d);
    v = $random(seed);
    xfer(1'h1, ATM_OFS_MODE_TWO, v);
    rd(ATM_OFS_MODE_TWO, v & ATM_MODE_MASK);
    for (int k = 0; k < 8; k++) begin
      `CHK("differential", v[2*k+7], dif[k])
      `CHK("signed", v[2*k+6], sgn[k])
    end
    xfer(1'h1, ATM_OFS_SCAN_CTL, {11'h0, v[4:0], 16'h0});
    rd(ATM_OFS_SCAN_CTL, {11'h0, v[4:0], 16'h0});
    `CHK("scan source", v[4:0], scs)
    $display("register test done");
    pulse(4'h2);
    for (int i = 0; i < 12; i++) begin
      c = (i < 11) ? 5'(i + 3) : 5'h1d;
      xfer(1'h1, ATM_OFS_TRIG_SEL, {11'h0, c, 11'h0, c});
      pulse(4'((i + 1) % 11));
      cq.push_back(4'h5);
      pulse(4'((i < 11) ? i : 10));
    end
    xfer(1'h1, ATM_OFS_TRIG_SEL, {11'h0, 5'h01, 11'h0, 5'h01});
    cq.push_back(4'h5);
    xfer(1'h1, ATM_OFS_SOFT, 32'h1);
    repeat (8) @(posedge clk);
    xfer(1'h1, ATM_OFS_TRIG_SEL, {11'h0, 5'h02, 11'h0, 5'h02});
    lvl <= 1'h1;
    xfer(1'h1, ATM_OFS_SOFT, 32'h2);
    repeat (4) @(posedge clk);
    #1 `CHK("level request", 4'h5, req)
    xfer(1'h1, ATM_OFS_SOFT, 32'h0);
    repeat (6) @(posedge clk);
    lvl <= 1'h0;
    `CHK("pending notes", 32'h0, 32'(cq.size() + rq.size()))
    $display("trigger test done");
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: inc/atm_pkg.sv */
/*
  atm_pkg: register offsets, field layouts, reset values and trigger codes
  of the converter trigger and input mode block.
  assumes a 32-bit AHB-Lite register bus with word aligned registers.
*/
package atm_pkg;
  // register byte offsets
  localparam logic [7:0] ATM_OFS_TRIG_SEL = 8'h00;
  localparam logic [7:0] ATM_OFS_MODE_TWO = 8'h04;
  localparam logic [7:0] ATM_OFS_SOFT = 8'h08;
  localparam logic [7:0] ATM_OFS_SCAN_CTL = 8'h0c;
  localparam logic [7:0] ATM_OFS_STATUS = 8'h10;
  // trigger select layout
  localparam int ATM_SEL_W = 5;
  localparam int ATM_SEL_STRIDE = 8;
  localparam int ATM_NUM_SEL = 4;
  localparam logic [31:0] ATM_TRIG_MASK = 32'h1f1f1f1f;
  localparam logic [31:0] ATM_TRIG_RESET = 32'h00000000;
  // mode register: inputs 19..26 use bits 6..21
  localparam logic [31:0] ATM_MODE_MASK = 32'h003fffc0;
  localparam logic [31:0] ATM_MODE_RESET = 32'h00000000;
  localparam int ATM_MODE_BASE = 16;
  localparam int ATM_MODE_FIRST = 19;
  localparam int ATM_MODE_LAST = 26;
  // soft trigger register bits
  localparam int ATM_SOFT_EDGE_BIT = 0;
  localparam int ATM_SOFT_LEVEL_BIT = 1;
  // scan control: source field at 20:16
  localparam int ATM_SCAN_LSB = 16;
  localparam logic [31:0] ATM_SCAN_MASK = 32'h001f0000;
  // trigger codes
  typedef enum logic [4:0] {
    ATM_TRG_NONE = 5'h00,
    ATM_TRG_SW_EDGE = 5'h01,
    ATM_TRG_SW_LEVEL = 5'h02,
    ATM_TRG_SCAN = 5'h03,
    ATM_TRG_EXT_EXTERNAL_INTERRUPT_ZERO = 5'h04,
    ATM_TRG_TIMER1 = 5'h05,
    ATM_TRG_TIMER3 = 5'h06,
    ATM_TRG_TIMER5 = 5'h07,
    ATM_TRG_OC1 = 5'h08,
    ATM_TRG_OC3 = 5'h09,
    ATM_TRG_OC5 = 5'h0a,
    ATM_TRG_CMP1 = 5'h0b,
    ATM_TRG_CMP2 = 5'h0c,
    ATM_TRG_CTU = 5'h0d,
    ATM_TRG_CTU_ALT = 5'h1d
  } atm_code_type;
  // bus data phase states
  typedef enum logic [1:0] {
    ATM_ST_IDLE = 2'b01,
    ATM_ST_DATA = 2'b10
  } atm_state_type;
endpackage

/* File: rtl/atm_trigger_mode.sv */
/*
  atm_trigger_mode: per-input trigger source selection, trigger edge
  detection, conversion request pulses and per-input sample mode bits.
  assumes an AHB-Lite master on i_clock and peripheral trigger levels
  that may come from other clocks or pins, hence are synchronised here.
  the bus slave answers every transfer at once and always with OKAY.
*/
// Functional notes
// RULE_01 - four 5-bit trigger selectors at bits 4-0, 12-8, 20-16, 28-24
// RULE_02 - code zero starts no conversion at all
// RULE_03 - code 1 converts on the global software edge trigger
// RULE_04 - code 2 converts while the global level software trigger is high
// RULE_05 - software choosing scan trigger also sets scan source and scan selects
// RULE_06 - code 4 converts on external interrupt zero
// RULE_07 - codes 5, 6, 7 convert on timer 1, 3, 5 period match
// RULE_08 - codes 8, 9, 10 convert on output compare 1, 3, 5
// RULE_09 - codes 11, 12 convert on comparator 1 and comparator 2 output
// RULE_10 - codes 13 and 29 both convert on a charge time unit event
// RULE_11 - software must not write reserved trigger codes
// RULE_12 - peripheral outputs trigger on their rising edge
// RULE_13 - mode bit 2*(n-16)+1 picks differential for inputs 19 to 26
// RULE_14 - sign bit 2*(n-16) picks signed results for inputs 19 to 26
// RULE_15 - unimplemented selector bits read zero; selectors reset to zero
// RULE_16 - sources are synchronised; one request per detected trigger event
`timescale 1ns/1ps
`default_nettype none
module atm_trigger_mode
  import atm_pkg::*;
#(
  parameter int NUM_SRC = 12
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_scan_trigger,
  input wire logic i_external_interrupt_zero,
  input wire logic i_timer_one,
  input wire logic i_timer_three,
  input wire logic i_timer_five,
  input wire logic i_output_compare_one,
  input wire logic i_output_compare_three,
  input wire logic i_output_compare_five,
  input wire logic i_comparator_one_output,
  input wire logic i_comparator_two_output,
  input wire logic i_charge_time_unit,
  output logic [ATM_NUM_SEL-1:0] o_convert_request,
  output logic [ATM_MODE_LAST-ATM_MODE_FIRST:0] o_input_differential,
  output logic [ATM_MODE_LAST-ATM_MODE_FIRST:0] o_input_signed,
  output logic [4:0] o_scan_trigger_source
);
  localparam int NUM_IN = ATM_MODE_LAST - ATM_MODE_FIRST + 1;

  // the source map below has eleven hardware sources and one tied-low slot
  if (NUM_SRC != 12) begin : g_bad_num_src
    $error("atm_trigger_mode: NUM_SRC must be 12");
  end

  // source index order inside the synchroniser vector
  localparam int SRC_SCAN = 0;
  localparam int SRC_EXTERNAL_INTERRUPT_ZERO = 1;
  localparam int SRC_T1 = 2;
  localparam int SRC_T3 = 3;
  localparam int SRC_T5 = 4;
  localparam int SRC_OC1 = 5;
  localparam int SRC_OC3 = 6;
  localparam int SRC_OC5 = 7;
  localparam int SRC_C1 = 8;
  localparam int SRC_C2 = 9;
  localparam int SRC_CTU = 10;
  localparam int SRC_LVL = 11;

  logic [31:0] trig_sel_r;
  logic [31:0] mode_two_r;
  logic [31:0] scan_ctl_r;
  logic soft_edge_r;
  logic soft_level_r;
  logic [NUM_SRC-1:0] sync1_r;
  logic [NUM_SRC-1:0] sync2_r;
  logic [NUM_SRC-1:0] prev_r;
  logic [ATM_NUM_SEL-1:0] req_r;
  logic [ATM_NUM_SEL-1:0] req_nxt;
  logic [ATM_NUM_SEL-1:0] seen_r;
  atm_state_type state_r;
  atm_state_type state_nxt;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // raw peripheral levels gathered for synchronising
  wire [NUM_SRC-1:0] src_raw;
  assign src_raw = {1'b0, i_charge_time_unit, i_comparator_two_output,
                    i_comparator_one_output, i_output_compare_five,
                    i_output_compare_three, i_output_compare_one, i_timer_five,
                    i_timer_three, i_timer_one, i_external_interrupt_zero,
                    i_scan_trigger};

  // two flop synchroniser; only the second stage feeds any logic
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= src_raw;
      sync2_r <= sync1_r; // [RULE_16]
    end
  end

  // edge history of the synchronised levels; idle low after reset
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= sync2_r;
    end
  end

  wire [NUM_SRC-1:0] rise;
  assign rise = sync2_r & ~prev_r; // [RULE_12]

  // event for one selector code
  function automatic logic code_event(input logic [4:0] code,
                                      input logic [NUM_SRC-1:0] r,
                                      input logic sw_edge,
                                      input logic sw_level);
    logic ev;
    ev = 1'b0;
    case (code)
      ATM_TRG_NONE: ev = 1'b0; // [RULE_02]
      ATM_TRG_SW_EDGE: ev = sw_edge; // [RULE_03]
      ATM_TRG_SW_LEVEL: ev = sw_level; // [RULE_04]
      ATM_TRG_SCAN: ev = r[SRC_SCAN];
      ATM_TRG_EXT_EXTERNAL_INTERRUPT_ZERO: ev = r[SRC_EXTERNAL_INTERRUPT_ZERO]; // [RULE_06]
      ATM_TRG_TIMER1: ev = r[SRC_T1]; // [RULE_07]
      ATM_TRG_TIMER3: ev = r[SRC_T3]; // [RULE_07]
      ATM_TRG_TIMER5: ev = r[SRC_T5]; // [RULE_07]
      ATM_TRG_OC1: ev = r[SRC_OC1]; // [RULE_08]
      ATM_TRG_OC3: ev = r[SRC_OC3]; // [RULE_08]
      ATM_TRG_OC5: ev = r[SRC_OC5]; // [RULE_08]
      ATM_TRG_CMP1: ev = r[SRC_C1]; // [RULE_09]
      ATM_TRG_CMP2: ev = r[SRC_C2]; // [RULE_09]
      ATM_TRG_CTU: ev = r[SRC_CTU]; // [RULE_10]
      ATM_TRG_CTU_ALT: ev = r[SRC_CTU]; // [RULE_10]
      default: ev = 1'b0; // reserved codes never trigger
    endcase
    return ev;
  endfunction

  // per-input request; level trigger asks every cycle while the software level bit is high
  always_comb begin
    req_nxt = '0;
    for (int i = 0; i < ATM_NUM_SEL; i++) begin
      req_nxt[i] = code_event(trig_sel_r[i*ATM_SEL_STRIDE +: ATM_SEL_W], rise,
                              soft_edge_r, soft_level_r); // [RULE_01] [RULE_16]
    end
  end

  // one registered request per detected event
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  // sticky record of requests, cleared only by reset
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_r <= '0;
    end else begin
      seen_r <= seen_r | req_r;
    end
  end

  assign o_convert_request = req_r;

  // true when a byte offset names the given register
  function automatic logic ofs_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    logic hit;
    hit = (addr == ofs);
    return hit;
  endfunction

  // bus address phase decode; the slave never inserts wait states
  wire addr_take;
  assign addr_take = i_hsel & i_hready & i_htrans[1];
  wire read_take;
  assign read_take = addr_take & ~i_hwrite;
  wire write_take;
  assign write_take = addr_take & i_hwrite;
  wire do_write;
  assign do_write = (state_r == ATM_ST_DATA) & wr_pend_r;

  // next bus phase: a data phase follows every accepted address phase
  always_comb begin
    state_nxt = ATM_ST_IDLE;
    case (state_r)
      ATM_ST_IDLE: begin
        state_nxt = addr_take ? ATM_ST_DATA : ATM_ST_IDLE;
      end
      ATM_ST_DATA: begin
        // a new address phase may overlap this data phase
        state_nxt = addr_take ? ATM_ST_DATA : ATM_ST_IDLE;
      end
      default: begin
        state_nxt = ATM_ST_IDLE;
      end
    endcase
  end

  // bus phase and the write flag of the pending data phase
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ATM_ST_IDLE;
      wr_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wr_pend_r <= write_take;
    end
  end

  // offset of the pending transfer, held between transfers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_r <= '0;
    end else if (addr_take) begin
      addr_r <= i_haddr[7:0];
    end
  end

  // data phase write strobes, one per register except status
  wire wr_trig_sel;
  assign wr_trig_sel = do_write & ofs_hit(addr_r, ATM_OFS_TRIG_SEL);
  wire wr_mode_two;
  assign wr_mode_two = do_write & ofs_hit(addr_r, ATM_OFS_MODE_TWO);
  wire wr_soft;
  assign wr_soft = do_write & ofs_hit(addr_r, ATM_OFS_SOFT);
  wire wr_scan_ctl;
  assign wr_scan_ctl = do_write & ofs_hit(addr_r, ATM_OFS_SCAN_CTL);

  // trigger selectors; unimplemented bits are never stored
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trig_sel_r <= ATM_TRIG_RESET; // [RULE_15]
    end else if (wr_trig_sel) begin
      trig_sel_r <= i_hwdata & ATM_TRIG_MASK; // [RULE_15]
    end
  end

  // sample mode bits of inputs 19..26
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_two_r <= ATM_MODE_RESET;
    end else if (wr_mode_two) begin
      mode_two_r <= i_hwdata & ATM_MODE_MASK;
    end
  end

  // scan trigger source; software must also set the scan selects
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scan_ctl_r <= '0;
    end else if (wr_scan_ctl) begin
      scan_ctl_r <= i_hwdata & ATM_SCAN_MASK;
    end
  end

  // software edge trigger is a one cycle pulse per write of its bit
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_edge_r <= 1'b0;
    end else begin
      soft_edge_r <= wr_soft & i_hwdata[ATM_SOFT_EDGE_BIT];
    end
  end

  // software level trigger holds until software clears it
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_level_r <= 1'b0;
    end else if (wr_soft) begin
      soft_level_r <= i_hwdata[ATM_SOFT_LEVEL_BIT];
    end
  end

  // read select terms, one per register; unmapped offsets read zero
  wire [7:0] rd_ofs;
  assign rd_ofs = i_haddr[7:0];
  wire [31:0] rd_trig_sel;
  assign rd_trig_sel = ofs_hit(rd_ofs, ATM_OFS_TRIG_SEL) ?
                       (trig_sel_r & ATM_TRIG_MASK) : '0; // [RULE_15]
  wire [31:0] rd_mode_two;
  assign rd_mode_two = ofs_hit(rd_ofs, ATM_OFS_MODE_TWO) ? mode_two_r : '0;
  wire [31:0] rd_soft;
  assign rd_soft = ofs_hit(rd_ofs, ATM_OFS_SOFT) ? {30'h0, soft_level_r, 1'b0} : '0;
  wire [31:0] rd_scan_ctl;
  assign rd_scan_ctl = ofs_hit(rd_ofs, ATM_OFS_SCAN_CTL) ? scan_ctl_r : '0;
  wire [31:0] rd_status;
  assign rd_status = ofs_hit(rd_ofs, ATM_OFS_STATUS) ? {24'h0, seen_r, req_r} : '0;

  // at most one select term is non-zero
  assign rdata_nxt = rd_trig_sel | rd_mode_two | rd_soft | rd_scan_ctl | rd_status;

  // read data is taken in the address phase and stands in the data phase
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= '0;
    end else if (read_take) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_hrdata = rdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_scan_trigger_source = scan_ctl_r[ATM_SCAN_LSB +: 5];

  // per-input mode bits for inputs 19..26
  always_comb begin
    o_input_differential = '0;
    o_input_signed = '0;
    for (int n = 0; n < NUM_IN; n++) begin
      o_input_differential[n] = mode_two_r[2*(n+ATM_MODE_FIRST-ATM_MODE_BASE)+1]; // [RULE_13]
      o_input_signed[n] = mode_two_r[2*(n+ATM_MODE_FIRST-ATM_MODE_BASE)]; // [RULE_14]
    end
  end
endmodule
`default_nettype wire
